//--- logic/icdiag_pkg.sv
// constants and types shared by the cache diagnostic access unit
package icdiag_pkg;
	localparam logic [11:0] CSR_SELECT = 12'h7C8;
	localparam logic [11:0] CSR_DATA_LO = 12'h7C9;
	localparam logic [11:0] CSR_CHECK = 12'h7CA;
	localparam logic [11:0] CSR_TRIGGER = 12'h7CB;
	localparam logic [11:0] CSR_DATA_HI = 12'h7CC;
	localparam int ARRAY_BIT = 24;
	localparam int WAY_HI = 21;
	localparam int WAY_LO = 20;
	localparam int IDX_HI = 16;
	localparam int IDX_LO = 3;
	localparam int IDX_W = 14;
	localparam int CHUNK_W = 3;
	localparam int TAG_LO = 11;
	localparam int LRU_HI = 6;
	localparam int LRU_LO = 4;
	localparam int DATA_CHK_W = 7;
	localparam int TAG_CHK_W = 5;
	localparam int SET_AW = 7;
	localparam logic [31:0] SELECT_RESET = 32'h00000000;
	localparam logic [31:0] SELECT_MASK = 32'h0131FFF8;
	localparam logic [31:0] TAGWORD_MASK = 32'hFFFFF871;

	typedef struct packed {
		logic array_sel;
		logic [1:0] way;
		logic [IDX_W-1:0] index;
	} icdiag_sel_t;

	typedef struct packed {
		logic [63:0] instr;
		logic [DATA_CHK_W-1:0] check;
	} icdiag_chunk_t;

	typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_LOAD} icdiag_state_t;
endpackage

//--- logic/icdiag_ram.sv
// small synchronous memory with registered read data
module icdiag_ram #(
	parameter int AW = 7,
	parameter int DW = 71
)(
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

//--- logic/icdiag_top.sv
// instruction cache diagnostic access unit over the core csr path
// Function
// - trigger read in data mode loads chunk
// - trigger read in tag mode loads tag
// - go write in data mode stores chunk
// - go write in tag mode stores tag
// - select bit 24 chooses data or tag
// - way field bits 21:20, two-way uses 20
// - tag access ignores chunk index bits
// - reserved select bits read zero
// - writable fields read back legal values
// - access outside debug mode is illegal
// - chunk has four parity or ecc seven
// - tag has one parity or ecc five
// - line holds eight or four chunks
// - data read fills low, high, check words
// - tag read fills low word and check
// - lru bits shared by whole set
// - low word holds bytes three to zero
// - high word holds bytes seven to four
module icdiag_top (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic CSR_REQ,
	input wire logic CSR_WE,
	input wire logic [11:0] CSR_ADDR,
	input wire logic [31:0] CSR_WDATA,
	input wire logic DEBUG_MODE,
	input wire logic FOUR_WAY,
	input wire logic LINE_64,
	input wire logic ECC_MODE,
	output logic [31:0] CSR_RDATA,
	output logic CSR_ILLEGAL,
	output logic CSR_BUSY
);
	logic [31:0] diag_location_select;
	logic [31:0] diag_data_low_word;
	logic [31:0] diag_data_high_word;
	logic [31:0] diag_check_bits_word;
	icdiag_pkg::icdiag_state_t state;
	logic hit;
	logic legal;
	logic go_read;
	logic go_write;
	logic [31:0] legal_sel;
	logic [1:0] way;
	logic [icdiag_pkg::IDX_W-1:0] idx;
	logic [icdiag_pkg::SET_AW-1:0] set_addr;
	logic [icdiag_pkg::SET_AW+1:0] way_set;
	logic [icdiag_pkg::SET_AW+icdiag_pkg::CHUNK_W+1:0] data_addr;
	logic [70:0] data_wdata;
	logic [70:0] data_rdata;
	logic [25:0] tag_wdata;
	logic [25:0] tag_rdata;
	logic [2:0] lru_rdata;
	logic data_we;
	logic tag_we;
	logic lru_we;
	logic is_tag;
	logic [31:0] legal_check;
	logic [31:0] legal_low;
	logic [(1<<(icdiag_pkg::SET_AW+2))-1:0] valid_bits;
	logic valid_q;

	assign hit = CSR_REQ && (CSR_ADDR == icdiag_pkg::CSR_SELECT
		|| CSR_ADDR == icdiag_pkg::CSR_DATA_LO
		|| CSR_ADDR == icdiag_pkg::CSR_DATA_HI
		|| CSR_ADDR == icdiag_pkg::CSR_CHECK
		|| CSR_ADDR == icdiag_pkg::CSR_TRIGGER);
	assign legal = hit && DEBUG_MODE && state == icdiag_pkg::ACC_IDLE;
	assign is_tag = diag_location_select[icdiag_pkg::ARRAY_BIT];
	assign go_read = legal && !CSR_WE
		&& CSR_ADDR == icdiag_pkg::CSR_TRIGGER;
	assign go_write = legal && CSR_WE
		&& CSR_ADDR == icdiag_pkg::CSR_TRIGGER && CSR_WDATA[0];
	// two-way caches drop the upper way bit so it reads back zero
	always_comb
	begin
		legal_sel = CSR_WDATA & icdiag_pkg::SELECT_MASK;
		if (!FOUR_WAY)
		begin
			legal_sel[icdiag_pkg::WAY_HI] = 1'b0;
		end
	end
	// low and check holding words keep only the bits the selected array and mode can use
	always_comb
	begin
		legal_low = is_tag
			? CSR_WDATA & icdiag_pkg::TAGWORD_MASK : CSR_WDATA;
		if (is_tag && !FOUR_WAY)
		begin
			legal_low[icdiag_pkg::LRU_HI:icdiag_pkg::LRU_LO+1] = 2'b00;
		end
		legal_check = 32'h00000000;
		if (ECC_MODE && is_tag)
		begin
			legal_check[icdiag_pkg::TAG_CHK_W-1:0] =
				CSR_WDATA[icdiag_pkg::TAG_CHK_W-1:0];
		end
		else if (ECC_MODE)
		begin
			legal_check[icdiag_pkg::DATA_CHK_W-1:0] =
				CSR_WDATA[icdiag_pkg::DATA_CHK_W-1:0];
		end
		else if (is_tag)
		begin
			legal_check[0] = CSR_WDATA[0];
		end
		else
		begin
			legal_check[3:0] = CSR_WDATA[3:0];
		end
	end
	assign way = diag_location_select[icdiag_pkg::WAY_HI:icdiag_pkg::WAY_LO];
	assign idx = diag_location_select[icdiag_pkg::IDX_HI:icdiag_pkg::IDX_LO];
	// index low bits pick the chunk, the next seven bits pick the set
	assign set_addr = LINE_64
		? idx[icdiag_pkg::SET_AW+2:3]
		: idx[icdiag_pkg::SET_AW+1:2];
	assign way_set = {way, set_addr};
	assign data_addr = {way_set,
		LINE_64 ? idx[2:0] : {1'b0, idx[1:0]}};
	assign data_wdata = {diag_data_high_word, diag_data_low_word,
		diag_check_bits_word[icdiag_pkg::DATA_CHK_W-1:0]};
	assign tag_wdata = {diag_data_low_word[31:icdiag_pkg::TAG_LO],
		diag_check_bits_word[icdiag_pkg::TAG_CHK_W-1:0]};
	assign data_we = go_write && !is_tag;
	assign tag_we = go_write && is_tag;
	assign lru_we = tag_we;

	// the chunk ram is indexed by the chunk within the line as well
	icdiag_ram #(.AW(icdiag_pkg::SET_AW + icdiag_pkg::CHUNK_W + 2),
		.DW(71)) u_data (
		.clk(CLK_SYS),
		.we(data_we),
		.addr(data_addr),
		.wdata(data_wdata),
		.rdata(data_rdata)
	);
	icdiag_ram #(.AW(icdiag_pkg::SET_AW + 2), .DW(26)) u_tag (
		.clk(CLK_SYS),
		.we(tag_we),
		.addr(way_set),
		.wdata(tag_wdata),
		.rdata(tag_rdata)
	);
	icdiag_ram #(.AW(icdiag_pkg::SET_AW), .DW(3)) u_lru (
		.clk(CLK_SYS),
		.we(lru_we),
		.addr(set_addr),
		.wdata(diag_data_low_word[icdiag_pkg::LRU_HI:icdiag_pkg::LRU_LO]),
		.rdata(lru_rdata)
	);

	// csr stalls while the ram read lands, so no later read sees stale data
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state <= icdiag_pkg::ACC_IDLE;
		end
		else
		begin
			case (state)
				icdiag_pkg::ACC_IDLE:
					if (go_read)
					begin
						state <= icdiag_pkg::ACC_READ;
					end
				icdiag_pkg::ACC_READ:
					state <= icdiag_pkg::ACC_LOAD;
				icdiag_pkg::ACC_LOAD:
					state <= icdiag_pkg::ACC_IDLE;
				default:
					state <= icdiag_pkg::ACC_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			CSR_BUSY <= 1'b0;
		end
		else
		begin
			CSR_BUSY <= go_read || state == icdiag_pkg::ACC_READ;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			diag_location_select <= icdiag_pkg::SELECT_RESET;
		end
		else if (legal && CSR_WE && CSR_ADDR == icdiag_pkg::CSR_SELECT)
		begin
			diag_location_select <= legal_sel;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			diag_data_low_word <= '0;
			diag_data_high_word <= '0;
			diag_check_bits_word <= '0;
		end
		else if (state == icdiag_pkg::ACC_READ)
		begin
			if (!is_tag)
			begin
				diag_data_high_word <= data_rdata[70:39];
				diag_data_low_word <= data_rdata[38:7];
				diag_check_bits_word <= {25'h0000000,
					ECC_MODE ? data_rdata[6:0] : {3'h0, data_rdata[3:0]}};
			end
			else
			begin
				diag_data_low_word <= {tag_rdata[25:5], 4'h0, lru_rdata,
					3'h0, valid_q};
				diag_check_bits_word <= {27'h0000000,
					ECC_MODE ? tag_rdata[4:0] : {4'h0, tag_rdata[0]}};
			end
		end
		else if (legal && CSR_WE)
		begin
			if (CSR_ADDR == icdiag_pkg::CSR_DATA_LO)
			begin
				diag_data_low_word <= legal_low;
			end
			if (CSR_ADDR == icdiag_pkg::CSR_DATA_HI)
			begin
				diag_data_high_word <= CSR_WDATA;
			end
			if (CSR_ADDR == icdiag_pkg::CSR_CHECK)
			begin
				diag_check_bits_word <= legal_check;
			end
		end
	end

	// valid bit kept in flops beside the tag, one per way and set
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			valid_bits <= '0;
			valid_q <= 1'b0;
		end
		else
		begin
			if (tag_we)
			begin
				valid_bits[way_set] <= diag_data_low_word[0];
			end
			valid_q <= valid_bits[way_set];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			CSR_RDATA <= '0;
			CSR_ILLEGAL <= 1'b0;
		end
		else
		begin
			CSR_ILLEGAL <= hit && !DEBUG_MODE;
			CSR_RDATA <= '0;
			if (legal && !CSR_WE)
			begin
				case (CSR_ADDR)
					icdiag_pkg::CSR_SELECT:
						CSR_RDATA <= diag_location_select;
					icdiag_pkg::CSR_DATA_LO:
						CSR_RDATA <= diag_data_low_word;
					icdiag_pkg::CSR_DATA_HI:
						CSR_RDATA <= diag_data_high_word;
					icdiag_pkg::CSR_CHECK:
						CSR_RDATA <= diag_check_bits_word;
					default:
						CSR_RDATA <= '0;
				endcase
			end
		end
	end

endmodule

//--- testbench/icdiag_properties.sv
// assertion checker for the cache diagnostic unit
module icdiag_checker (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic CSR_REQ,
	input wire logic CSR_WE,
	input wire logic [11:0] CSR_ADDR,
	input wire logic [31:0] CSR_WDATA,
	input wire logic DEBUG_MODE,
	input wire logic FOUR_WAY,
	input wire logic LINE_64,
	input wire logic ECC_MODE,
	input wire logic [31:0] CSR_RDATA,
	input wire logic CSR_ILLEGAL,
	input wire logic CSR_BUSY
);
	timeunit 1ns;
	timeprecision 100ps;
	logic map, ok, rd;
	assign map = CSR_ADDR inside {[12'h7C8:12'h7CC]};
	assign ok = CSR_REQ && DEBUG_MODE && !CSR_BUSY && map;
	assign rd = ok && !CSR_WE;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	property p_ill;
		CSR_REQ && map && !DEBUG_MODE && !CSR_BUSY |=> CSR_ILLEGAL;
	endproperty
	a_ill: assert property (p_ill)
		else $error("no illegal pulse");
	property p_dbg;
		ok |=> !CSR_ILLEGAL;
	endproperty
	a_dbg: assert property (p_dbg)
		else $error("illegal in debug mode");
	property p_nodata;
		CSR_REQ && !DEBUG_MODE |=> CSR_RDATA == 32'h0;
	endproperty
	a_nodata: assert property (p_nodata)
		else $error("data outside debug mode");
	property p_busy;
		rd && CSR_ADDR == 12'h7CB |=> CSR_BUSY [*2] ##1 !CSR_BUSY;
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy window wrong");
	property p_rsvd;
		rd && CSR_ADDR == 12'h7C8
			|=> (CSR_RDATA & ~icdiag_pkg::SELECT_MASK) == 32'h0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved select bit set");
	property p_chk;
		rd && CSR_ADDR == 12'h7CA |=> CSR_RDATA[31:7] == 25'h0;
	endproperty
	a_chk: assert property (p_chk)
		else $error("check word reserved bit set");
	property p_way;
		rd && CSR_ADDR == 12'h7C8 && !FOUR_WAY |=> !CSR_RDATA[21];
	endproperty
	a_way: assert property (p_way)
		else $error("upper way bit in two-way");
	property p_unmap;
		CSR_REQ && !map |=> CSR_RDATA == 32'h0 && !CSR_ILLEGAL;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped access answered");
	property p_quiet;
		!CSR_REQ |=> CSR_RDATA == 32'h0 && !CSR_ILLEGAL;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("output without request");
endmodule
bind icdiag_top icdiag_checker u_icdiag_checker (.*);

//--- testbench/icdiag_cache_model.sv
// behavioural mirror of the cache arrays for expectations
module icdiag_cache_model;
	timeunit 1ns;
	timeprecision 100ps;
	// chunk is 64 instr bits above seven ecc bits
	logic [70:0] chunk [int];
	// lru is keyed by set only, so every way sees the same bits
	logic [2:0] lru [int];
endmodule

//--- testbench/testbench.sv
// self-checking bench for the cache diagnostic unit
`define CHK(n, e, a) check(n, e, a);
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK_SYS = 0, RST_B = 0, CSR_REQ = 0, CSR_WE = 0, il;
	logic DEBUG_MODE = 1, FOUR_WAY = 1, LINE_64 = 1, ECC_MODE = 1;
	logic [11:0] CSR_ADDR = 12'h0;
	logic [31:0] CSR_WDATA = 32'h0, CSR_RDATA, q;
	logic CSR_ILLEGAL, CSR_BUSY;
	logic [70:0] v;
	int miscompares = 0, num_checks = 0, cycles = 0;
	icdiag_top u_icdiag_top (.*);
	icdiag_cache_model u_icdiag_cache_model ();
	initial forever #2 CLK_SYS = ~CLK_SYS;
	// ceiling well above the few hundred cycles the tests need
	always @(posedge CLK_SYS)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			results();
		end
	end
	task check(input string n, input logic [31:0] e, a);
		num_checks++;
		if (a !== e)
		begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, e, a);
		end
	endtask
	// one access; waits out the busy window after a trigger read
	task csr(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(negedge CLK_SYS);
		CSR_REQ = 1;
		CSR_WE = w;
		CSR_ADDR = ad;
		CSR_WDATA = d;
		@(negedge CLK_SYS);
		CSR_REQ = 0;
		q = CSR_RDATA;
		il = CSR_ILLEGAL;
		while (CSR_BUSY)
			@(negedge CLK_SYS);
	endtask
	task t_select;
		csr(0, 12'h7C8, 0);
		`CHK("select reset", 32'h0, q)
		csr(1, 12'h7C8, 32'hFFFFFFFF);
		csr(0, 12'h7C8, 0);
		`CHK("select", icdiag_pkg::SELECT_MASK, q)
		FOUR_WAY = 0;
		csr(1, 12'h7C8, 32'hFFFFFFFF);
		csr(0, 12'h7C8, 0);
		`CHK("two-way select", 32'h0111FFF8, q)
		FOUR_WAY = 1;
		$display("t_select done");
	endtask
	task t_data;
		v = {32'hCAFE1234, 32'h89ABCDEF, 7'h5A};
		u_icdiag_cache_model.chunk[9] = v;
		csr(1, 12'h7C8, 32'h00200048);
		csr(1, 12'h7C9, v[38:7]);
		csr(1, 12'h7CC, v[70:39]);
		// arbitrary check bits stand for a deliberate error injection
		csr(1, 12'h7CA, {25'h0, v[6:0]});
		csr(1, 12'h7CB, 32'h1);
		csr(1, 12'h7C9, 0);
		csr(1, 12'h7CC, 0);
		csr(1, 12'h7CA, 0);
		csr(0, 12'h7CB, 0);
		v = u_icdiag_cache_model.chunk[9];
		csr(0, 12'h7C9, 0);
		`CHK("low word", v[38:7], q)
		csr(0, 12'h7CC, 0);
		`CHK("high word", v[70:39], q)
		csr(0, 12'h7CA, 0);
		`CHK("chunk check", {25'h0, v[6:0]}, q)
		$display("t_data done");
	endtask
	task t_tag;
		u_icdiag_cache_model.lru[1] = 3'h5;
		csr(1, 12'h7C8, 32'h01100040);
		csr(1, 12'h7C9, 32'hABCDE851);
		csr(1, 12'h7CA, 32'h15);
		csr(1, 12'h7CB, 32'h1);
		// chunk bits 5:3 differ but name the same line
		csr(1, 12'h7C8, 32'h01100078);
		csr(0, 12'h7CB, 0);
		csr(0, 12'h7C9, 0);
		`CHK("tag word", 32'hABCDE851, q)
		csr(0, 12'h7CA, 0);
		`CHK("tag check", 32'h15, q)
		csr(1, 12'h7C8, 32'h01000040);
		csr(0, 12'h7CB, 0);
		csr(0, 12'h7C9, 0);
		`CHK("lru", u_icdiag_cache_model.lru[1], q[6:4])
		`CHK("valid way0", 32'h0, q[0])
		$display("t_tag done");
	endtask
	// walks one aligned line chunk by chunk; indices stay small, so the
	// unused upper index bits are left at zero
	task t_line(input logic l64, input logic par);
		int n;
		LINE_64 = l64;
		ECC_MODE = !par;
		n = l64 ? 8 : 4;
		for (int i = 0; i < n; i++)
		begin
			csr(1, 12'h7C8, 32'h00300080 | (i << 3));
			csr(1, 12'h7C9, 32'h11110000 + i);
			csr(1, 12'h7CC, 32'h22220000 + i);
			csr(1, 12'h7CA, 32'h00000070 + i);
			csr(1, 12'h7CB, 32'h1);
		end
		for (int i = 0; i < n; i++)
		begin
			csr(1, 12'h7C8, 32'h00300080 | (i << 3));
			csr(0, 12'h7CB, 0);
			csr(0, 12'h7C9, 0);
			`CHK("line low", 32'h11110000 + i, q)
			csr(0, 12'h7CC, 0);
			`CHK("line high", 32'h22220000 + i, q)
			csr(0, 12'h7CA, 0);
			`CHK("line check", par ? 32'h0 + i : 32'h70 + i, q)
		end
		$display("t_line done");
	endtask
	task t_illegal;
		DEBUG_MODE = 0;
		csr(0, 12'h7C9, 0);
		`CHK("illegal", 32'h1, {q[30:0], il})
		DEBUG_MODE = 1;
		csr(0, 12'h7CD, 0);
		`CHK("unmapped", 32'h0, {q[30:0], il})
		$display("t_illegal done");
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(negedge CLK_SYS);
		RST_B = 1;
		t_select();
		t_data();
		t_tag();
		t_line(1, 0);
		t_line(0, 1);
		t_illegal();
		results();
	end
endmodule
